// ===== design/rxdi_regs.svh
`ifndef RXDI_REGS_SVH
`define RXDI_REGS_SVH

// register indices; byte address is four times the index
`define RXDI_IDX_BLK_EN 8'h04
`define RXDI_IDX_CFG 8'h11
`define RXDI_IDX_IEN 8'h12
`define RXDI_IDX_IST 8'h14

// field positions
`define RXDI_BLK_RX_EN_BIT 7
`define RXDI_CFG_PERIOD_SEL_BIT 7
`define RXDI_CFG_LOF_BIT 6
`define RXDI_CFG_OOF_BIT 5
`define RXDI_CFG_LOS_BIT 4
`define RXDI_LOS_BIT 1
`define RXDI_LOF_BIT 2
`define RXDI_OOF_BIT 3

// reset values
`define RXDI_BLK_EN_RST 8'h00
`define RXDI_IEN_RST 8'h00
`define RXDI_IST_RST 8'h00
`define RXDI_PERIOD_SEL_RST 1'b0

// writable masks
`define RXDI_BLK_EN_WMASK 8'h83
`define RXDI_IEN_WMASK 8'h1f

// timing
`define RXDI_CLK_KHZ 100000
`define RXDI_LOF_SHORT_US 1000
`define RXDI_LOF_LONG_US 3000
`define RXDI_OOF_ERR_FRAMES 4
`define RXDI_LOS_ZERO_RUN 32
`define RXDI_LOS_CLR_WINDOW 32
`define RXDI_LOS_CLR_RUN 4

`endif

// ===== design/rxdi_pkg.sv
package rxdi_pkg;

  typedef enum logic [1:0] {
    RXDI_IN_FRAME,
    RXDI_HUNT,
    RXDI_VERIFY
  } rxdi_frm_state_t;

  // live defects, packed in flag bit order, shifted down one (struct bit 0 is flag bit 1)
  typedef struct packed {
    logic framing_lost;
    logic frame_loss;
    logic signal_missing;
  } rxdi_defect_t;

  typedef struct packed {
    logic tick;
    logic fas_err;
    logic fas_found;
  } rxdi_frame_ev_t;

endpackage

// ===== design/rxdi_top.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "rxdi_regs.svh"
// Behaviour
// RL1 - enabled defect change drives interrupt request pin low
// RL2 - signal-loss declare and clear both raise a change interrupt
// RL3 - signal-loss change sets status flag bit 1
// RL4 - live signal-loss state readable at configuration bit 4
// RL5 - host may send far-end failure while serviced defect holds
// RL6 - host stops far-end failure once serviced defect reads false
// RL7 - out-of-frame declare and clear both raise a change interrupt
// RL8 - four consecutive errored frames declare out-of-frame
// RL9 - entering in-frame from verify or out-of-frame clears out-of-frame
// RL10 - enable bit 3 gates the out-of-frame change interrupt
// RL11 - out-of-frame change sets status flag bit 3
// RL12 - live out-of-frame state readable at configuration bit 5
// RL13 - enable bit written one enables, zero disables
// RL14 - frame-loss declare and clear both raise a change interrupt
// RL15 - out-of-frame lasting 1 ms or 3 ms declares frame loss
// RL16 - return to in-frame clears frame loss
// RL17 - frame-loss enable and status flags sit at bit 2
// RL18 - flags stay until status read; read clears, releases request
// RL19 - enable bit 1 gates the signal-loss change interrupt
// RL20 - block receive enable bit 7 gates receive interrupts to pin
// RL21 - loss pin high or 32 zeros declares signal loss
// RL22 - loss pin low or 32 bits without 4 zeros clears it; code clears only when the pin is low and the bit check releases
module rxdi_top
  import rxdi_pkg::*;
#(
  parameter int LOF_SHORT_CYC = `RXDI_LOF_SHORT_US * (`RXDI_CLK_KHZ / 1000),
  parameter int LOF_LONG_CYC = `RXDI_LOF_LONG_US * (`RXDI_CLK_KHZ / 1000)
)
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [9:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // line pins
  input wire logic line_unit_signal_missing_in_i,
  input wire logic rx_line_positive_i,
  input wire logic rx_line_negative_i,
  input wire logic rx_bit_valid_i,
  // framer events, same clock
  input wire logic frame_tick_i,
  input wire logic fas_err_i,
  input wire logic fas_found_i,
  // interrupt request and live defects
  output logic int_n_o,
  output logic rx_signal_missing_state_o,
  output logic rx_framing_lost_state_o,
  output logic rx_frame_loss_state_o
);

  localparam int LOF_W = 20;
  localparam logic [LOF_W-1:0] LOF_SHORT = LOF_SHORT_CYC[LOF_W-1:0];
  localparam logic [LOF_W-1:0] LOF_LONG = LOF_LONG_CYC[LOF_W-1:0];
  localparam logic [5:0] ZERO_RUN = 6'(`RXDI_LOS_ZERO_RUN);
  localparam logic [5:0] CLR_WIN = 6'(`RXDI_LOS_CLR_WINDOW);
  localparam logic [5:0] CLR_RUN = 6'(`RXDI_LOS_CLR_RUN);
  localparam logic [2:0] OOF_ERRS = 3'(`RXDI_OOF_ERR_FRAMES);

  // pin synchronisers
  logic [2:0] pin_raw;
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  assign pin_raw = {line_unit_signal_missing_in_i, rx_line_positive_i, rx_line_negative_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
        end
        else if (ce_i)
        begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
        end
      end
    end
  endgenerate

  wire los_pin = pin_s2[2];
  wire bit_zero = ~pin_s2[1] & ~pin_s2[0];

  // signal-loss detection on line bits
  logic [5:0] zero_run;
  logic [5:0] clean_bits;
  logic los_digital;
  wire [5:0] next_zero_run = bit_zero ? ((zero_run == ZERO_RUN) ? zero_run : zero_run + 6'h01)
                                      : 6'h00;
  wire run4 = bit_zero & (next_zero_run >= CLR_RUN);
  wire [5:0] next_clean = run4 ? 6'h00 : ((clean_bits == CLR_WIN) ? clean_bits
                                                                   : clean_bits + 6'h01);
  wire los_declare = next_zero_run == ZERO_RUN; // [RL21]
  wire los_release = next_clean == CLR_WIN; // [RL22]

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      zero_run <= 6'h00;
      clean_bits <= 6'h00;
      los_digital <= 1'b0;
    end
    else if (ce_i && rx_bit_valid_i)
    begin
      zero_run <= next_zero_run;
      clean_bits <= next_clean;
      if (los_declare)
        los_digital <= 1'b1;
      else if (los_release)
        los_digital <= 1'b0;
    end
  end

  // receive framer
  rxdi_frame_ev_t fev;
  assign fev = '{tick: frame_tick_i, fas_err: fas_err_i, fas_found: fas_found_i};

  rxdi_frm_state_t frm_state;
  rxdi_frm_state_t next_frm_state;
  logic [2:0] err_frames;
  logic [2:0] next_err_frames;

  always_comb
  begin
    next_frm_state = frm_state;
    next_err_frames = err_frames;
    case (frm_state)
      RXDI_IN_FRAME:
      begin
        if (fev.tick)
        begin
          next_err_frames = fev.fas_err ? err_frames + 3'h1 : 3'h0;
          if (next_err_frames == OOF_ERRS)
            next_frm_state = RXDI_HUNT; // [RL8]
        end
      end
      RXDI_HUNT:
      begin
        next_err_frames = 3'h0;
        if (fev.fas_found)
          next_frm_state = RXDI_VERIFY;
      end
      RXDI_VERIFY:
      begin
        if (fev.tick)
          next_frm_state = fev.fas_err ? RXDI_HUNT : RXDI_IN_FRAME; // [RL9]
      end
      default:
        next_frm_state = RXDI_HUNT;
    endcase
  end

  // frame-loss timer while out of frame
  logic period_sel;
  logic [LOF_W-1:0] oof_cycles;
  logic lof_state;
  wire oof_now = frm_state != RXDI_IN_FRAME;
  wire [LOF_W-1:0] lof_limit = period_sel ? LOF_LONG : LOF_SHORT;
  wire lof_expire = oof_now & (oof_cycles >= lof_limit - 20'h00001); // [RL15]
  wire in_frame_next = next_frm_state == RXDI_IN_FRAME;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      frm_state <= RXDI_HUNT;
      err_frames <= 3'h0;
      oof_cycles <= '0;
      lof_state <= 1'b1;
    end
    else if (ce_i)
    begin
      frm_state <= next_frm_state;
      err_frames <= next_err_frames;
      oof_cycles <= (oof_now && !lof_expire) ? oof_cycles + 20'h00001 : '0;
      if (in_frame_next)
        lof_state <= 1'b0; // [RL16]
      else if (lof_expire)
        lof_state <= 1'b1;
    end
  end

  // live defects and change detection
  rxdi_defect_t dnow;
  rxdi_defect_t dlast;
  assign dnow = '{framing_lost: oof_now, frame_loss: lof_state, signal_missing: los_pin | los_digital};

  // apb decode
  wire [7:0] idx = paddr_i[9:2];
  wire apb_done = psel_i & penable_i & pready_o;
  wire hit_blk = idx == `RXDI_IDX_BLK_EN;
  wire hit_cfg = idx == `RXDI_IDX_CFG;
  wire hit_ien = idx == `RXDI_IDX_IEN;
  wire hit_ist = idx == `RXDI_IDX_IST;
  wire mapped = hit_blk | hit_cfg | hit_ien | hit_ist;
  wire wr_done = apb_done & pwrite_i;
  wire ist_read = apb_done & ~pwrite_i & hit_ist; // [RL18]

  logic [7:0] blk_en;
  logic [7:0] ien;
  logic [7:0] ist;
  wire [7:0] cfg_val = {period_sel, dnow.frame_loss, dnow.framing_lost, dnow.signal_missing, 4'h0}; // [RL4] [RL12]

  // per-source flag set; set wins over read clear
  logic [3:1] flag_set;
  generate
    for (gi = 1; gi <= 3; gi++)
    begin : g_flag
      // [RL2] [RL7] [RL14] on both edges of each defect
      assign flag_set[gi] = (dnow[gi-1] != dlast[gi-1]) & ien[gi]; // [RL10] [RL19] [RL17]
    end
  endgenerate

  wire [7:0] next_ist = {4'h0, flag_set, 1'b0}
                      | (ist_read ? 8'h00 : ist); // [RL3] [RL11] [RL18]
  wire irq = blk_en[`RXDI_BLK_RX_EN_BIT] & |(next_ist & ien); // [RL20] [RL1]

  wire [7:0] rd_byte = hit_blk ? blk_en :
                       hit_cfg ? cfg_val :
                       hit_ien ? ien :
                       hit_ist ? ist : 8'h00;

  // register writes, one register per block
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      blk_en <= `RXDI_BLK_EN_RST;
    else if (ce_i && wr_done && hit_blk)
      blk_en <= pwdata_i[7:0] & `RXDI_BLK_EN_WMASK;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ien <= `RXDI_IEN_RST;
    else if (ce_i && wr_done && hit_ien)
      ien <= pwdata_i[7:0] & `RXDI_IEN_WMASK; // [RL13]
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      period_sel <= `RXDI_PERIOD_SEL_RST;
    else if (ce_i && wr_done && hit_cfg)
      period_sel <= pwdata_i[`RXDI_CFG_PERIOD_SEL_BIT];
  end

  // previous defect state for change detection
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      dlast <= '{framing_lost: 1'b1, frame_loss: 1'b1, signal_missing: 1'b0};
    else if (ce_i)
      dlast <= dnow;
  end

  // sticky flags, cleared by status read
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ist <= `RXDI_IST_RST;
    else if (ce_i)
      ist <= next_ist;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      int_n_o <= 1'b1;
    else if (ce_i)
      int_n_o <= ~irq; // [RL1]
  end

  // apb answer: ready one cycle into the access phase
  wire access_first = psel_i & penable_i & ~pready_o;
  wire [31:0] rd_word = pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pready_o <= 1'b0;
    else if (ce_i)
      pready_o <= access_first;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      prdata_o <= 32'h0000_0000;
    else if (ce_i && access_first)
      prdata_o <= rd_word;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pslverr_o <= 1'b0;
    else if (ce_i)
      pslverr_o <= access_first & ~mapped;
  end

  // live defect outputs
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rx_signal_missing_state_o <= 1'b0;
    else if (ce_i)
      rx_signal_missing_state_o <= dnow.signal_missing;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rx_framing_lost_state_o <= 1'b1;
    else if (ce_i)
      rx_framing_lost_state_o <= dnow.framing_lost;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rx_frame_loss_state_o <= 1'b1;
    else if (ce_i)
      rx_frame_loss_state_o <= dnow.frame_loss;
  end

endmodule // rxdi_top

// ===== sim/rxdi_host_model.sv
`timescale 1ns/1ps
module rxdi_host_model (
  // clock and reset
  input logic clk_i,
  input logic rstn_i,
  // completed register read
  input logic rd_i,
  input logic [7:0] idx_i,
  input logic [7:0] data_i,
  // far-end failure request
  output logic far_end_receive_failure_o
);
  // send while a serviced defect reads true
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      far_end_receive_failure_o <= 1'h0;
    else if (rd_i && idx_i == 8'h11)
      far_end_receive_failure_o <= data_i[5] | data_i[4];
  end
endmodule // rxdi_host_model

// ===== sim/rxdi_top_properties.sv
`timescale 1ns/1ps
module rxdi_top_properties (
  // clock and reset
  input logic clk_i,
  input logic rstn_i,
  // apb
  input logic psel_i,
  input logic penable_i,
  input logic pwrite_i,
  input logic [9:0] paddr_i,
  input logic [31:0] pwdata_i,
  input logic [31:0] prdata_o,
  input logic pready_o,
  // request and defects
  input logic int_n_o,
  input logic rx_signal_missing_state_o,
  input logic rx_framing_lost_state_o,
  input logic rx_frame_loss_state_o
);
  logic [7:0] ien;
  logic blk;
  wire done = psel_i && penable_i && pready_o;
  wire [7:0] idx = paddr_i[9:2];
  wire st_rd = done && !pwrite_i && idx == 8'h14;
  wire cf_rd = done && !pwrite_i && idx == 8'h11;
  wire signal_missing = rx_signal_missing_state_o;
  wire framing_lost = rx_framing_lost_state_o;
  wire frame_loss = rx_frame_loss_state_o;
  // shadow of the enables
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ien <= 8'h00;
      blk <= 1'h0;
    end
    else if (done && pwrite_i)
    begin
      if (idx == 8'h12)
        ien <= pwdata_i[7:0];
      if (idx == 8'h04)
        blk <= pwdata_i[7];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_int_los;
    $changed(signal_missing) && ien[1] && blk |-> ##[0:2] !int_n_o;
  endproperty
  a_int_los: assert property (p_int_los) else $error("no request on los change");
  property p_int_oof;
    $changed(framing_lost) && ien[3] && blk |-> ##[0:2] !int_n_o;
  endproperty
  a_int_oof: assert property (p_int_oof) else $error("no request on oof change");
  property p_int_lof;
    $changed(frame_loss) && ien[2] && blk |-> ##[0:2] !int_n_o;
  endproperty
  a_int_lof: assert property (p_int_lof) else $error("no request on lof change");
  property p_int_gate;
    (!blk || ien[3:1] == 3'h0) [*2] |-> int_n_o;
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("request while gated");
  property p_int_hold;
    !int_n_o && !done && !$past(done) |=> !int_n_o;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("request dropped early");
  property p_flag_cause;
    st_rd && !int_n_o && !$past(int_n_o) |-> (prdata_o[3:1] & ien[3:1]) != 3'h0;
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("request without flag");
  property p_live_read;
    cf_rd && $stable(signal_missing) && $stable(framing_lost) && $stable(frame_loss) |-> prdata_o[6:4] == {frame_loss, framing_lost, signal_missing};
  endproperty
  a_live_read: assert property (p_live_read) else $error("live bits differ");
  property p_lof_rise;
    $rose(frame_loss) |-> framing_lost;
  endproperty
  a_lof_rise: assert property (p_lof_rise) else $error("lof without oof");
  c_int: cover property (!int_n_o);
  c_flags: cover property (st_rd && prdata_o[3:1] != 3'h0);
  c_lof: cover property ($rose(frame_loss));
endmodule // rxdi_top_properties
bind rxdi_top rxdi_top_properties u_props (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pready_o, .int_n_o, .rx_signal_missing_state_o,
  .rx_framing_lost_state_o, .rx_frame_loss_state_o);

// ===== sim/rxdi_top_test.sv
`timescale 1ns/1ps
module rxdi_top_test;
  import rxdi_pkg::*;
  typedef struct {logic [9:0] a; logic we; logic [7:0] w; logic [7:0] r; logic e;} rxdi_row_t;
  logic clk_i = 1'h0, rstn_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic loss_i = 1'h0, pos_i = 1'h0, valid_i = 1'h0, e;
  logic [9:0] paddr_i = 10'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, r;
  logic pready_o, pslverr_o, int_n_o, los_o, oof_o, lof_o, far_end_receive_failure;
  rxdi_frame_ev_t ev_i = 3'h0;
  int fails = 0, samples_checked = 0;
  rxdi_row_t rows [9] = '{'{10'h044, 1'h0, 8'h00, 8'h60, 1'h0}, '{10'h048, 1'h0, 8'h00, 8'h00, 1'h0},
    '{10'h050, 1'h0, 8'h00, 8'h00, 1'h0}, '{10'h010, 1'h0, 8'h00, 8'h00, 1'h0},
    '{10'h048, 1'h1, 8'hff, 8'h1f, 1'h0}, '{10'h010, 1'h1, 8'hff, 8'h83, 1'h0},
    '{10'h044, 1'h1, 8'h80, 8'he0, 1'h0}, '{10'h050, 1'h1, 8'hff, 8'h00, 1'h0},
    '{10'h3fc, 1'h1, 8'hff, 8'h00, 1'h1}};
  always #5 clk_i = ~clk_i;
  rxdi_top #(.LOF_SHORT_CYC(20), .LOF_LONG_CYC(60)) uut (.clk_i, .rstn_i, .ce_i(1'h1), .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .line_unit_signal_missing_in_i(loss_i), .rx_line_positive_i(pos_i), .rx_line_negative_i(1'h0),
    .rx_bit_valid_i(valid_i), .frame_tick_i(ev_i.tick), .fas_err_i(ev_i.fas_err),
    .fas_found_i(ev_i.fas_found), .int_n_o, .rx_signal_missing_state_o(los_o),
    .rx_framing_lost_state_o(oof_o), .rx_frame_loss_state_o(lof_o));
  rxdi_host_model host (.clk_i, .rstn_i, .rd_i(psel_i & penable_i & pready_o & !pwrite_i),
    .idx_i(paddr_i[9:2]), .data_i(prdata_o[7:0]), .far_end_receive_failure_o(far_end_receive_failure));
  task automatic apb(input logic [9:0] a, input logic we, input logic [7:0] w);
    int n;
    n = 0;
    psel_i <= 1'h1;
    pwrite_i <= we;
    paddr_i <= a;
    pwdata_i <= {24'h0, w};
    @(posedge clk_i);
    penable_i <= 1'h1;
    do @(posedge clk_i); while (pready_o !== 1'h1 && ++n < 50);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chb(input string n, input logic x, input logic g);
    chk(n, {31'h0, x}, {31'h0, g});
  endtask
  task automatic frame(input rxdi_frame_ev_t v);
    ev_i <= v;
    @(posedge clk_i);
    ev_i <= 3'h0;
    @(posedge clk_i);
  endtask
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    complete_run;
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'h1;
    @(posedge clk_i);
    foreach (rows[i])
    begin
      if (rows[i].we)
        apb(rows[i].a, 1'h1, rows[i].w);
      apb(rows[i].a, 1'h0, 8'h00);
      chk("reg data", {24'h0, rows[i].r}, r);
      chb("reg error", rows[i].e, e);
    end
    $display("register rows done");
    apb(10'h048, 1'h1, 8'h0c);
    for (int s = 0; s < 2; s++)
    begin
      apb(10'h044, 1'h1, {s[0], 7'h00});
      frame(3'h1);
      frame(3'h4);
      @(posedge clk_i);
      chb("in frame oof", 1'h0, oof_o);
      chb("request", 1'h0, int_n_o);
      repeat (3) frame(3'h6);
      frame(3'h4);
      repeat (3) frame(3'h6);
      chb("oof at three", 1'h0, oof_o);
      frame(3'h6);
      @(posedge clk_i);
      chb("oof at four", 1'h1, oof_o);
      repeat ((s ? 60 : 20) - 5) @(posedge clk_i);
      chb("lof early", 1'h0, lof_o);
      repeat (10) @(posedge clk_i);
      chb("lof late", 1'h1, lof_o);
      apb(10'h050, 1'h0, 8'h00);
      chk("status", 32'h0c, r);
      repeat (3) @(posedge clk_i);
      chb("released", 1'h1, int_n_o);
    end
    $display("framing done");
    frame(3'h1);
    frame(3'h4);
    apb(10'h050, 1'h0, 8'h00);
    apb(10'h048, 1'h1, 8'h0e);
    loss_i <= 1'h1;
    repeat (6) @(posedge clk_i);
    chb("los pin", 1'h1, los_o);
    apb(10'h044, 1'h0, 8'h00);
    chb("cfg los", 1'h1, r[4]);
    chb("far_end_receive_failure on", 1'h1, far_end_receive_failure);
    loss_i <= 1'h0;
    repeat (6) @(posedge clk_i);
    chb("los pin off", 1'h0, los_o);
    apb(10'h044, 1'h0, 8'h00);
    chb("far_end_receive_failure off", 1'h0, far_end_receive_failure);
    apb(10'h050, 1'h0, 8'h00);
    chk("status los", 32'h02, r);
    apb(10'h048, 1'h1, 8'h0c);
    valid_i <= 1'h1;
    repeat (31) @(posedge clk_i);
    valid_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    chb("zeros 31", 1'h0, los_o);
    valid_i <= 1'h1;
    @(posedge clk_i);
    valid_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    chb("zeros 32", 1'h1, los_o);
    pos_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    valid_i <= 1'h1;
    repeat (32) @(posedge clk_i);
    valid_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    chb("ones 32", 1'h0, los_o);
    chb("masked", 1'h1, int_n_o);
    apb(10'h050, 1'h0, 8'h00);
    chk("status masked", 32'h00, r);
    $display("signal loss done");
    complete_run;
  end
endmodule // rxdi_top_test
